// ===== rtl/idh_handoff_regs.sv
// What this block does
// - Control bits 7..4 suppress per-channel terminal count onto end-of-process line.
// - Suppression ignored for memory-to-memory transfers; normal terminal count kept.
// - Control bit 3 holds DMA core reset asserted until written back to 0.
// - Read-only bit 2 shows live address enable; never raises interrupt.
// - Read-only bit 0 shows live hold request; never raises interrupt.
// - Bit 1 drives hold grant; microcontroller side releases shared ISA signals.
// - Add wait states at 24MHz with DMA 2/4MHz, or 12MHz with 2MHz.
// - Status bits 7..4 show request pending for channels 3..0, read-only.
// - Status bits 3..0 show terminal count reached for channels 3..0.
// - Status mirrors core channel status live; reading it changes nothing.
// - Mirror follows core clearing its terminal-count bits after status read.
// - Interrupt flag latches on rising edge of any unmasked status bit.
// - Mask bit 0 enables, 1 masks; all mask bits reset to 1.
module idh_handoff_regs
	import idh_pkg::*;
#(
	parameter int WAIT_CYCLES = idh_pkg::ISA_WAIT_CYCLES
) (
	input  wire logic                       clk_sys_i,
	input  wire logic                       arst_n_i,
	input  wire logic [idh_pkg::ADDR_W-1:0] avs_address_i,
	input  wire logic                       avs_read_i,
	input  wire logic                       avs_write_i,
	input  wire logic [idh_pkg::DATA_W-1:0] avs_writedata_i,
	input  wire logic [3:0]                 avs_byteenable_i,
	output logic      [idh_pkg::DATA_W-1:0] avs_readdata_o,
	output logic                            avs_waitrequest_o,
	input  wire logic [1:0]                 mcu_clk_sel_i,
	input  wire logic [1:0]                 dma_clk_sel_i,
	input  wire logic                       dma_hold_request_i,
	input  wire logic                       dma_addr_enable_i,
	input  wire logic [idh_pkg::REG_W-1:0]  dma_core_channel_status_i,
	input  wire logic [idh_pkg::NUM_CH-1:0] dma_core_tc_i,
	input  wire logic                       dma_mem_to_mem_i,
	output logic                            end_of_process_line_o,
	output logic                            dma_core_reset_o,
	output logic                            dma_hold_grant_o,
	output logic                            mcu_isa_release_o,
	output logic                            isa_wait_needed_o,
	output logic                            dma_interrupt_flag_o
);
	import idh_pkg::*;

	localparam int SYNC_W = REG_W + 2;
	localparam logic [7:0] WAIT_LOAD = 8'(WAIT_CYCLES);

	// =====================================================================
	// Decoding helpers
	function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [15:0] idx);
		hit = (a[ADDR_W-1:2] == idx) && (a[1:0] == 2'h0);
	endfunction

	function automatic logic slow_pair(input logic [1:0] mcu, input logic [1:0] dma);
		slow_pair = ((mcu == MCU_CLK_24M) && ((dma == DMA_CLK_2M) || (dma == DMA_CLK_4M)))
			|| ((mcu == MCU_CLK_12M) && (dma == DMA_CLK_2M));
	endfunction

	// =====================================================================
	// Register selects, shared by read and write paths
	logic sel_ctrl;
	logic sel_stat;
	logic sel_mask;
	logic sel_irq;

	always_comb
	begin
		sel_ctrl = hit(avs_address_i, IDX_HANDOFF_CTRL);
		sel_stat = hit(avs_address_i, IDX_STATUS_MIR);
		sel_mask = hit(avs_address_i, IDX_STATUS_MASK);
		sel_irq  = hit(avs_address_i, IDX_IRQ_STATUS);
	end

	// =====================================================================
	// Software register state, read back by the bus slave
	logic [REG_W-1:0] ctrl_ff;
	logic [REG_W-1:0] nxt_ctrl;
	logic [REG_W-1:0] mask_ff;
	logic [REG_W-1:0] nxt_mask;
	logic [REG_W-1:0] status_prev_ff;
	logic [REG_W-1:0] nxt_status_prev;
	logic             irq_flag_ff;
	logic             nxt_irq_flag;
	logic             rise_hit;

	// =====================================================================
	// Synchronisers for core-side levels
	idh_sync_if #(.W(SYNC_W)) sync_bus ();
	logic [REG_W-1:0] status_sync;
	logic             hold_req_sync;
	logic             addr_en_sync;

	assign sync_bus.raw = {dma_hold_request_i, dma_addr_enable_i,
		dma_core_channel_status_i};
	assign status_sync   = sync_bus.synced[REG_W-1:0];
	assign addr_en_sync  = sync_bus.synced[REG_W];
	assign hold_req_sync = sync_bus.synced[REG_W+1];

	idh_sync #(.W(SYNC_W)) u_sync
	(
		.clk_sys_i (clk_sys_i),
		.arst_n_i  (arst_n_i),
		.sif       (sync_bus)
	);

	// =====================================================================
	// Bus slave state
	idh_bus_state_t    state_ff;
	idh_bus_state_t    nxt_state;
	logic [7:0]        wait_cnt_ff;
	logic [7:0]        nxt_wait_cnt;
	logic [DATA_W-1:0] rdata_ff;
	logic [DATA_W-1:0] nxt_rdata;
	logic              wait_needed_ff;
	logic              nxt_wait_needed;
	logic [REG_W-1:0]  read_mux;
	logic              wr_ack;

	always_comb
	begin
		read_mux = '0;
		if (sel_ctrl)
		begin
			read_mux = ctrl_ff;
			read_mux[CTRL_ADDR_EN]  = addr_en_sync;
			read_mux[CTRL_HOLD_REQ] = hold_req_sync;
		end
		else if (sel_stat)
			read_mux = status_sync;
		else if (sel_mask)
			read_mux = mask_ff;
		else if (sel_irq)
			read_mux[IRQ_FLAG_BIT] = irq_flag_ff;
	end

	always_comb
	begin
		nxt_state       = state_ff;
		nxt_wait_cnt    = wait_cnt_ff;
		nxt_rdata       = rdata_ff;
		nxt_wait_needed = slow_pair(mcu_clk_sel_i, dma_clk_sel_i);
		unique case (state_ff)
			BUS_IDLE:
			begin
				if (avs_read_i || avs_write_i)
				begin
					if (wait_needed_ff)
					begin
						nxt_state    = BUS_WAIT;
						nxt_wait_cnt = WAIT_LOAD;
					end
					else
					begin
						nxt_state = BUS_ACK;
						nxt_rdata = {{(DATA_W-REG_W){1'b0}}, read_mux};
					end
				end
			end
			BUS_WAIT:
			begin
				// Counts down to one: WAIT_CYCLES cycles in BUS_WAIT, then BUS_ACK
				if (wait_cnt_ff <= 8'h01)
				begin
					nxt_state = BUS_ACK;
					nxt_rdata = {{(DATA_W-REG_W){1'b0}}, read_mux};
				end
				else
					nxt_wait_cnt = wait_cnt_ff - 8'h01;
			end
			BUS_ACK:
				nxt_state = BUS_IDLE;
			default:
				nxt_state = BUS_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			state_ff       <= BUS_IDLE;
			wait_cnt_ff    <= 8'h00;
			rdata_ff       <= '0;
			wait_needed_ff <= 1'b0;
		end
		else
		begin
			state_ff       <= nxt_state;
			wait_cnt_ff    <= nxt_wait_cnt;
			rdata_ff       <= nxt_rdata;
			wait_needed_ff <= nxt_wait_needed;
		end
	end

	assign avs_waitrequest_o = (state_ff != BUS_ACK);
	assign avs_readdata_o    = rdata_ff;
	assign isa_wait_needed_o = wait_needed_ff;
	assign wr_ack            = (state_ff == BUS_ACK) && avs_write_i && avs_byteenable_i[0];

	// =====================================================================
	// Software registers and interrupt flag
	logic [REG_W-1:0] rise_bits;

	// Rising edge of each unmasked mirror bit
	genvar b;
	generate
		for (b = 0; b < REG_W; b++)
		begin : g_rise
			assign rise_bits[b] = status_sync[b] && !status_prev_ff[b]
				&& !mask_ff[b];
		end
	endgenerate

	always_comb
	begin
		nxt_ctrl        = ctrl_ff;
		nxt_mask        = mask_ff;
		nxt_status_prev = status_sync;
		rise_hit        = |rise_bits;
		nxt_irq_flag    = irq_flag_ff;
		if (wr_ack && sel_ctrl)
		begin
			nxt_ctrl = avs_writedata_i[REG_W-1:0];
			nxt_ctrl[CTRL_ADDR_EN]  = 1'b0;
			nxt_ctrl[CTRL_HOLD_REQ] = 1'b0;
		end
		if (wr_ack && sel_mask)
			nxt_mask = avs_writedata_i[REG_W-1:0];
		if (wr_ack && sel_irq && avs_writedata_i[IRQ_FLAG_BIT])
			nxt_irq_flag = 1'b0;
		// Set wins over a clear in the same cycle
		if (rise_hit)
			nxt_irq_flag = 1'b1;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			ctrl_ff        <= CTRL_RESET;
			mask_ff        <= MASK_RESET;
			// Same as synchroniser reset, so no false edge
			status_prev_ff <= '0;
			irq_flag_ff    <= 1'b0;
		end
		else
		begin
			ctrl_ff        <= nxt_ctrl;
			mask_ff        <= nxt_mask;
			status_prev_ff <= nxt_status_prev;
			irq_flag_ff    <= nxt_irq_flag;
		end
	end

	assign dma_interrupt_flag_o = irq_flag_ff;

	// =====================================================================
	// Core-facing outputs
	logic [NUM_CH-1:0] tc_pass;
	logic              eop_ff;
	logic              nxt_eop;
	logic              grant_ff;
	logic              nxt_grant;
	logic              core_rst_ff;
	logic              nxt_core_rst;

	// Memory-to-memory transfers keep their terminal count
	genvar ch;
	generate
		for (ch = 0; ch < NUM_CH; ch++)
		begin : g_tc
			assign tc_pass[ch] = dma_core_tc_i[ch]
				&& (!ctrl_ff[CTRL_SUPPRESS_LSB+ch] || dma_mem_to_mem_i);
		end
	endgenerate

	always_comb
	begin
		nxt_eop      = |tc_pass;
		nxt_grant    = nxt_ctrl[CTRL_HOLD_GRANT];
		nxt_core_rst = nxt_ctrl[CTRL_CORE_RESET];
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			eop_ff      <= 1'b0;
			grant_ff    <= 1'b0;
			core_rst_ff <= 1'b0;
		end
		else
		begin
			eop_ff      <= nxt_eop;
			grant_ff    <= nxt_grant;
			core_rst_ff <= nxt_core_rst;
		end
	end

	assign end_of_process_line_o = eop_ff;
	assign dma_hold_grant_o      = grant_ff;
	// Shared ISA pins float while the core owns the bus
	assign mcu_isa_release_o     = grant_ff;
	assign dma_core_reset_o      = core_rst_ff;
endmodule

// ===== rtl/idh_pkg.sv
package idh_pkg;

	// =====================================================================
	// Register indices; byte address is four times the index
	localparam logic [15:0] IDX_HANDOFF_CTRL = 16'h7F70;
	localparam logic [15:0] IDX_STATUS_MIR   = 16'h7F73;
	localparam logic [15:0] IDX_STATUS_MASK  = 16'h7F74;
	localparam logic [15:0] IDX_IRQ_STATUS   = 16'h7F75;
	localparam int          ADDR_W           = 18;
	localparam int          DATA_W           = 32;
	localparam int          REG_W            = 8;
	localparam int          NUM_CH           = 4;

	// =====================================================================
	// Control, status and interrupt register fields
	localparam int CTRL_SUPPRESS_LSB = 4;
	localparam int CTRL_CORE_RESET   = 3;
	localparam int CTRL_ADDR_EN      = 2;
	localparam int CTRL_HOLD_GRANT   = 1;
	localparam int CTRL_HOLD_REQ     = 0;
	localparam int STAT_REQ_LSB      = 4;
	localparam int STAT_DONE_LSB     = 0;
	localparam int IRQ_FLAG_BIT      = 0;

	// =====================================================================
	// Reset values
	localparam logic [7:0] CTRL_RESET = 8'h00;
	localparam logic [7:0] MASK_RESET = 8'hFF;

	// =====================================================================
	// Clock rate selects
	localparam logic [1:0] DMA_CLK_STOP = 2'h0;
	localparam logic [1:0] DMA_CLK_2M   = 2'h1;
	localparam logic [1:0] DMA_CLK_4M   = 2'h2;
	localparam logic [1:0] DMA_CLK_8M   = 2'h3;
	localparam logic [1:0] MCU_CLK_OTH  = 2'h0;
	localparam logic [1:0] MCU_CLK_12M  = 2'h1;
	localparam logic [1:0] MCU_CLK_24M  = 2'h2;

	// =====================================================================
	// Timing
	localparam int CLK_SYS_MHZ      = 200;
	localparam int ISA_WAIT_NS      = 20;
	localparam int ISA_WAIT_CYCLES  = (ISA_WAIT_NS * CLK_SYS_MHZ + 999) / 1000;
	localparam int SYNC_STAGES      = 2;

	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_WAIT = 2'b01,
		BUS_ACK  = 2'b10
	} idh_bus_state_t;

endpackage

// ===== rtl/idh_sync.sv
module idh_sync #(
	parameter int W = 8
) (
	input  wire logic clk_sys_i,
	input  wire logic arst_n_i,
	idh_sync_if.dst   sif
);
	import idh_pkg::*;

	logic [W-1:0] stage1_ff;
	logic [W-1:0] stage2_ff;
	logic [W-1:0] nxt_stage1;
	logic [W-1:0] nxt_stage2;

	// =====================================================================
	// Two-flop synchroniser, first stage read only by second
	always_comb
	begin
		nxt_stage1 = sif.raw;
		nxt_stage2 = stage1_ff;
	end

	always_ff @(posedge clk_sys_i or negedge arst_n_i)
	begin
		if (!arst_n_i)
		begin
			stage1_ff <= '0;
			stage2_ff <= '0;
		end
		else
		begin
			stage1_ff <= nxt_stage1;
			stage2_ff <= nxt_stage2;
		end
	end

	assign sif.synced = stage2_ff;
endmodule

// ===== rtl/idh_sync_if.sv
interface idh_sync_if #(parameter int W = 8);
	logic [W-1:0] raw;
	logic [W-1:0] synced;
	modport src (output raw, input synced);
	modport dst (input raw, output synced);
endinterface

// ===== tb/idh_core_model.sv
module idh_core_model (
	input  wire logic       clk_sys_i,
	input  wire logic       arst_n_i,
	input  wire logic       core_reset_i,
	input  wire logic       hold_grant_i,
	input  wire logic       want_bus_i,
	input  wire logic [7:0] status_i,
	input  wire logic [3:0] tc_i,
	input  wire logic       m2m_i,
	output logic            hold_request_o,
	output logic            addr_enable_o,
	output logic      [7:0] status_o,
	output logic      [3:0] tc_o,
	output logic            m2m_o
);
	timeunit 1ns;
	timeprecision 1ps;
	// Core held quiet while in reset
	always_ff @(posedge clk_sys_i or negedge arst_n_i)
		if (!arst_n_i)
			{hold_request_o, addr_enable_o, status_o, tc_o, m2m_o} <= 15'h0;
		else if (core_reset_i)
			{hold_request_o, addr_enable_o, status_o, tc_o, m2m_o} <= 15'h0;
		else
		begin
			hold_request_o <= want_bus_i;
			addr_enable_o <= want_bus_i && hold_grant_i;
			status_o <= status_i;
			tc_o <= tc_i;
			m2m_o <= m2m_i;
		end
endmodule

// ===== tb/idh_sva.sv
module idh_sva #(
	parameter int WAIT_CYCLES = 4
) (
	input wire logic       clk_sys_i,
	input wire logic       arst_n_i,
	input wire logic       avs_read_i,
	input wire logic       avs_write_i,
	input wire logic       avs_waitrequest_o,
	input wire logic [3:0] dma_core_tc_i,
	input wire logic       dma_mem_to_mem_i,
	input wire logic       end_of_process_line_o,
	input wire logic       dma_core_reset_o,
	input wire logic       dma_hold_grant_o,
	input wire logic       mcu_isa_release_o,
	input wire logic       isa_wait_needed_o,
	input wire logic [7:0] dma_core_channel_status_i,
	input wire logic       dma_interrupt_flag_o
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MAX_WAIT = WAIT_CYCLES + 1;
	wire req = avs_read_i || avs_write_i;
	wire acc = avs_write_i && !avs_waitrequest_o;
	default clocking cb @(posedge clk_sys_i);
	endclocking
	default disable iff (!arst_n_i);
	// ======
	// Checks
	a_eop_cause: assert property (end_of_process_line_o |-> $past(|dma_core_tc_i))
		else $error("end of process without count");
	a_eop_memcopy: assert property ($past(dma_mem_to_mem_i && |dma_core_tc_i)
		|-> end_of_process_line_o) else $error("memory copy count lost");
	a_answer_bound: assert property ($rose(req) |-> ##[1:MAX_WAIT] !avs_waitrequest_o)
		else $error("bus answer late");
	a_fast_answer: assert property ($rose(req) && !isa_wait_needed_o |=> !avs_waitrequest_o)
		else $error("fast access delayed");
	a_slow_answer: assert property ($rose(req) && isa_wait_needed_o |=> avs_waitrequest_o)
		else $error("wait state missing");
	a_ack_single: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
		else $error("answer longer than one cycle");
	a_idle_wait: assert property (!$past(req) |-> avs_waitrequest_o)
		else $error("answer without request");
	a_grant_release: assert property (dma_hold_grant_o == mcu_isa_release_o)
		else $error("grant and release differ");
	a_out_hold: assert property (!$past(acc) |-> $stable({dma_core_reset_o, dma_hold_grant_o}))
		else $error("control output moved without write");
	a_irq_cause: assert property ($rose(dma_interrupt_flag_o)
		|-> $past(dma_core_channel_status_i, 3) != 8'h00) else $error("flag without status");
	c_irq: cover property ($rose(dma_interrupt_flag_o));
	c_slow: cover property ($rose(req) && isa_wait_needed_o);
	c_grant: cover property ($rose(dma_hold_grant_o));
endmodule

// ===== tb/tb_idh_handoff_regs.sv
module tb_idh_handoff_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import idh_pkg::*;
	localparam int WT = 2;
	localparam logic [17:0] C = {IDX_HANDOFF_CTRL, 2'h0};
	localparam logic [17:0] S = {IDX_STATUS_MIR, 2'h0};
	localparam logic [17:0] M = {IDX_STATUS_MASK, 2'h0};
	localparam logic [17:0] I = {IDX_IRQ_STATUS, 2'h0};
	logic clk = 1'h0, rst_n = 1'h0, rd = 1'h0, wr = 1'h0, want = 1'h0, m2m = 1'h0;
	logic [17:0] adr = 18'h0;
	logic [31:0] wd = 32'h0, q, rdata;
	logic [3:0] tc = 4'h0, ctc;
	logic [1:0] mck = 2'h0, dck = 2'h0;
	logic [7:0] st = 8'h0, cst;
	logic wreq, eop, crst, grant, rel, isaw, flag, dma_hold_request, aen, mm;
	int bad_count = 0, comparisons = 0, w, n;
	always #2.5 clk = ~clk;
	idh_handoff_regs #(.WAIT_CYCLES(WT)) u_dut (.clk_sys_i(clk), .arst_n_i(rst_n),
		.avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd),
		.avs_byteenable_i(4'hF), .avs_readdata_o(rdata), .avs_waitrequest_o(wreq),
		.mcu_clk_sel_i(mck), .dma_clk_sel_i(dck), .dma_hold_request_i(dma_hold_request),
		.dma_addr_enable_i(aen), .dma_core_channel_status_i(cst), .dma_core_tc_i(ctc),
		.dma_mem_to_mem_i(mm), .end_of_process_line_o(eop), .dma_core_reset_o(crst),
		.dma_hold_grant_o(grant), .mcu_isa_release_o(rel), .isa_wait_needed_o(isaw),
		.dma_interrupt_flag_o(flag));
	idh_core_model u_core (.clk_sys_i(clk), .arst_n_i(rst_n), .core_reset_i(crst),
		.hold_grant_i(grant), .want_bus_i(want), .status_i(st), .tc_i(tc), .m2m_i(m2m),
		.hold_request_o(dma_hold_request), .addr_enable_o(aen), .status_o(cst), .tc_o(ctc), .m2m_o(mm));
	// ======
	// Tasks
	task chk(input logic [31:0] s, e);
		comparisons++;
		if (s !== e)
		begin
			bad_count++;
			$display("unexpected at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task conclude;
		$display("mismatches %0d, compares %0d", bad_count, comparisons);
		if (bad_count == 0 && comparisons > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task bus(input logic w1, input logic [17:0] a, input logic [31:0] d);
		int i;
		@(posedge clk);
		rd <= !w1;
		wr <= w1;
		adr <= a;
		wd <= d;
		w = 0;
		for (i = 0; i < 40; i++)
		begin
			@(posedge clk);
			if (wreq === 1'h0)
				break;
			w++;
		end
		if (i == 40)
		begin
			bad_count++;
			conclude();
		end
		q = rdata;
		rd <= 1'h0;
		wr <= 1'h0;
	endtask
	task rchk(input logic [17:0] a, input logic [31:0] e);
		bus(1'h0, a, 32'h0);
		chk(q, e);
	endtask
	task settle;
		repeat (6) @(posedge clk);
	endtask
	// ======
	// Sequence
	initial
	begin
		repeat (4) @(posedge clk);
		rst_n <= 1'h1;
		rchk(C, 32'h0);
		chk(w, 1);
		rchk(M, 32'hFF);
		rchk(I, 32'h0);
		rchk(18'h1FDC4, 32'h0);
		for (n = 0; n < 4; n++)
		begin
			bus(1'h1, C, 32'h10 << n);
			@(posedge clk);
			tc <= 4'h1 << n;
			settle();
			chk(eop, 1'h0);
			@(posedge clk);
			m2m <= 1'h1;
			settle();
			chk(eop, 1'h1);
			@(posedge clk);
			m2m <= 1'h0;
			tc <= 4'h1 << ((n + 1) % 4);
			settle();
			chk(eop, 1'h1);
			tc <= 4'h0;
		end
		want <= 1'h1;
		bus(1'h1, C, 32'h08);
		settle();
		rchk(C, 32'h08);
		chk(crst, 1'h1);
		bus(1'h1, C, 32'h00);
		settle();
		rchk(C, 32'h01);
		bus(1'h1, C, 32'h02);
		settle();
		rchk(C, 32'h07);
		chk(rel, 1'h1);
		chk(flag, 1'h0);
		bus(1'h1, C, 32'h00);
		repeat (300) @(posedge clk);
		rchk(C, 32'h01);
		want <= 1'h0;
		st <= 8'hA5;
		settle();
		rchk(S, 32'hA5);
		rchk(S, 32'hA5);
		@(posedge clk);
		st <= 8'hA0;
		settle();
		rchk(S, 32'hA0);
		bus(1'h1, S, 32'hFF);
		rchk(S, 32'hA0);
		@(posedge clk);
		st <= 8'hA1;
		settle();
		chk(flag, 1'h0);
		bus(1'h1, M, 32'hFE);
		@(posedge clk);
		st <= 8'hA0;
		settle();
		@(posedge clk);
		st <= 8'hA1;
		settle();
		chk(flag, 1'h1);
		bus(1'h1, I, 32'h01);
		rchk(I, 32'h0);
		bus(1'h1, M, 32'h00);
		want <= 1'h1;
		bus(1'h1, C, 32'h02);
		settle();
		chk(flag, 1'h0);
		bus(1'h1, C, 32'h00);
		want <= 1'h0;
		for (n = 0; n < 12; n++)
		begin
			@(posedge clk);
			mck <= 2'(n / 4);
			dck <= 2'(n % 4);
			settle();
			chk(isaw, n == 5 || n == 9 || n == 10);
		end
		@(posedge clk);
		dck <= 2'h1;
		settle();
		rchk(S, 32'hA1);
		chk(w, 1 + WT);
		conclude();
	end
endmodule
bind idh_handoff_regs idh_sva #(.WAIT_CYCLES(WAIT_CYCLES)) u_sva (.clk_sys_i(clk_sys_i),
	.arst_n_i(arst_n_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
	.avs_waitrequest_o(avs_waitrequest_o), .dma_core_tc_i(dma_core_tc_i),
	.dma_mem_to_mem_i(dma_mem_to_mem_i), .end_of_process_line_o(end_of_process_line_o),
	.dma_core_reset_o(dma_core_reset_o), .dma_hold_grant_o(dma_hold_grant_o),
	.mcu_isa_release_o(mcu_isa_release_o), .isa_wait_needed_o(isa_wait_needed_o),
	.dma_core_channel_status_i(dma_core_channel_status_i),
	.dma_interrupt_flag_o(dma_interrupt_flag_o));
